// file: tb/mpbfe_host_model.sv
// Host model: an 8-bit controller driving strobes, address and data on the two ports.
// Assumes the bench chooses the wiring; lines the host releases read back inverted.
`timescale 1ns/1ns
module mpbfe_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] low_o,
   input  wire logic       low_oe,
   input  wire logic [7:0] high_o,
   input  wire logic       high_oe,
   output      logic [7:0] low_pin,
   output      logic [7:0] high_pin,
   output      logic       ale,
   output      logic       wr_ctl,
   output      logic       rd_ctl,
   output      logic       fe_ctl
);
   logic [7:0] lo_q = 8'h00;
   logic [7:0] hi_q = 8'h00;
   logic       lo_en = 1'b0;
   logic       hi_en = 1'b0;
   // A released line never repeats its last value, so stale data cannot pass
   assign low_pin  = low_oe ? low_o : (lo_en ? lo_q : ~lo_q);
   assign high_pin = high_oe ? high_o : (hi_en ? hi_q : ~hi_q);
   initial begin
      ale = 1'b0;
      {wr_ctl, rd_ctl, fe_ctl} = 3'h7;
   end
   task automatic drive(input logic [7:0] lo, hi, input logic le, he);
      @(negedge ref_clk);
      {lo_q, hi_q, lo_en, hi_en} = {lo, hi, le, he};
   endtask : drive
   task automatic ctrl(input logic w, r, f);
      @(negedge ref_clk);
      {wr_ctl, rd_ctl, fe_ctl} = {w, r, f};
   endtask : ctrl
   // Strobe held three cycles so its synchronised copy is surely seen
   task automatic addr_phase(input logic [7:0] lo, hi);
      drive(lo, hi, 1'b1, 1'b1);
      ale = 1'b1;
      repeat (3) @(negedge ref_clk);
      ale = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask : addr_phase
endmodule : mpbfe_host_model

// file: tb/tb_top.sv
// Bench for the host bus front end: latch, read, write, control styles and reset.
// Assumes the host model drives the pins and the bench plays the decode logic.
`timescale 1ns/1ns
module tb_top;
   import mpbfe_pkg::*;
   logic              ref_clk = 1'b0;
   logic              arst_n = 1'b0;
   mpbfe_bus_e        bus_mode = MPBFE_BUS_MUX;
   mpbfe_wr_e         wr_style = MPBFE_WR_STROBE;
   mpbfe_rd_e         rd_style = MPBFE_RD_STROBE;
   mpbfe_ale_e        ale_style = MPBFE_ALE_HIGH;
   logic              wide_addr_host = 1'b0;
   logic              fetch_is_enable = 1'b1;
   logic              block_select = 1'b0;
   logic [ADW-1:0]    rd_data = 8'h00;
   logic [ADW-1:0]    low_addr_data_port_i, low_addr_data_port_o, high_addr_data_port_i, high_addr_data_port_o;
   logic [ADW-1:0]    wr_data;
   logic              low_addr_data_port_oe, high_addr_data_port_oe, addr_strobe_in, write_ctrl_input;
   logic              read_ctrl_input, fetch_ctrl_input, wr_pulse, rd_active, wr_ctrl_to_logic;
   logic              rd_ctrl_to_logic, fetch_to_logic, generic_in_to_logic, flash_abort;
   logic [ADDR_W-1:0] latched_addr;
   int                n_mismatch = 0;
   int                n_checks = 0;

   mpbfe_front_end i_dut (.ref_clk, .arst_n, .bus_mode, .wr_style, .rd_style, .ale_style, .wide_addr_host,
      .fetch_is_enable, .low_addr_data_port_i, .low_addr_data_port_o, .low_addr_data_port_oe,
      .high_addr_data_port_i, .high_addr_data_port_o, .high_addr_data_port_oe, .addr_strobe_in,
      .write_ctrl_input, .read_ctrl_input, .fetch_ctrl_input, .block_select, .rd_data, .latched_addr,
      .wr_data, .wr_pulse, .rd_active, .wr_ctrl_to_logic, .rd_ctrl_to_logic, .fetch_to_logic,
      .generic_in_to_logic, .flash_abort);
   mpbfe_host_model i_host (.ref_clk, .low_o(low_addr_data_port_o), .low_oe(low_addr_data_port_oe),
      .high_o(high_addr_data_port_o), .high_oe(high_addr_data_port_oe), .low_pin(low_addr_data_port_i),
      .high_pin(high_addr_data_port_i), .ale(addr_strobe_in), .wr_ctl(write_ctrl_input),
      .rd_ctl(read_ctrl_input), .fe_ctl(fetch_ctrl_input));

   initial forever #2 ref_clk = ~ref_clk;

   task automatic check(input logic [19:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic do_reset();
      if (arst_n) @(negedge ref_clk);
      arst_n = 1'b0;
      cyc(3);
      check({low_addr_data_port_oe, high_addr_data_port_oe}, 2'h0);
      check(latched_addr, 20'h00000);
      check({flash_abort, wr_ctrl_to_logic, rd_ctrl_to_logic}, 3'h7);
      arst_n = 1'b1;
      cyc(1);
      check(flash_abort, 1'b0);
      check({rd_active, low_addr_data_port_oe, wr_pulse}, 3'h0);
      cyc(3);
   endtask : do_reset
   task automatic read_case(input mpbfe_bus_e m, input logic [7:0] lo, hi, d, input logic sel);
      logic [19:0] got;
      logic [1:0]  oe_exp;
      {bus_mode, block_select, rd_data} = {m, sel, d};
      oe_exp = !sel ? 2'h0 : (m == MPBFE_BUS_PAGE) ? 2'h2 : (m == MPBFE_BUS_NONMUX) ? 2'h0 : 2'h1;
      i_host.addr_phase(lo, hi);
      got = latched_addr;
      if (m == MPBFE_BUS_BURST) check(latched_addr[19:4], {hi, lo});
      else check(latched_addr[15:0], {hi, lo});
      i_host.drive(~lo, ~hi, 1'b1, 1'b1);
      cyc(3);
      check(latched_addr, got);
      i_host.drive(lo, hi, 1'b0, 1'b0);
      i_host.ctrl(1'b1, 1'b0, 1'b1);
      cyc(5);
      check({high_addr_data_port_oe, low_addr_data_port_oe}, oe_exp);
      if (oe_exp[0]) check(low_addr_data_port_i, d);
      if (oe_exp[1]) check(high_addr_data_port_i, d);
      i_host.ctrl(1'b1, 1'b1, 1'b1);
      cyc(5);
      check({high_addr_data_port_oe, low_addr_data_port_oe}, 2'h0);
   endtask : read_case
   task automatic style_case(input mpbfe_rd_e s, input mpbfe_wr_e w, input logic wide, input logic [2:0] on_v, off_v);
      {rd_style, wr_style, wide_addr_host, block_select, bus_mode} = {s, w, wide, 1'b1, MPBFE_BUS_MUX};
      i_host.ctrl(off_v[2], off_v[1], off_v[0]);
      i_host.addr_phase(8'h3C, 8'hA5);
      i_host.drive(8'h00, 8'h00, 1'b0, 1'b0);
      i_host.ctrl(on_v[2], on_v[1], on_v[0]);
      cyc(5);
      check({rd_active, low_addr_data_port_oe}, 2'h3);
      check({wr_ctrl_to_logic, rd_ctrl_to_logic}, on_v[2:1]);
      i_host.ctrl(off_v[2], off_v[1], off_v[0]);
      cyc(5);
      check({rd_active, low_addr_data_port_oe}, 2'h0);
   endtask : style_case
   task automatic write_case(input logic [7:0] d);
      {rd_style, wr_style, wide_addr_host, bus_mode} = {MPBFE_RD_STROBE, MPBFE_WR_STROBE, 1'b0, MPBFE_BUS_MUX};
      i_host.addr_phase(8'h12, 8'h34);
      i_host.drive(d, 8'h34, 1'b1, 1'b1);
      i_host.ctrl(1'b0, 1'b1, 1'b1);
      cyc(4);
      i_host.ctrl(1'b1, 1'b1, 1'b1);
      for (int i = 0; i < 10 && wr_pulse !== 1'b1; i++) cyc(1);
      if (wr_pulse !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
      check(wr_data, d);
      check(low_addr_data_port_oe, 1'b0);
   endtask : write_case
   task automatic fetch_case();
      fetch_is_enable = 1'b0;
      for (int p = 0; p < 2; p++) begin
         i_host.ctrl(1'b1, 1'b1, p[0]);
         cyc(5);
         check(generic_in_to_logic, p[0]);
      end
      fetch_is_enable = 1'b1;
      i_host.ctrl(1'b1, 1'b1, 1'b0);
      cyc(5);
      check({fetch_to_logic, rd_active}, 2'h1);
      i_host.ctrl(1'b1, 1'b1, 1'b1);
      cyc(5);
   endtask : fetch_case

   initial begin
      // Reset held from power-up for three cycles
      do_reset();
      for (int m = 0; m < 4; m++) read_case(mpbfe_bus_e'(m), 8'h5A + 8'(m), 8'hC3 - 8'(m), 8'h96 + 8'(m), 1'b1);
      read_case(MPBFE_BUS_MUX, 8'hFF, 8'h00, 8'h81, 1'b0);
      ale_style = MPBFE_AS_RISE;
      read_case(MPBFE_BUS_BURST, 8'h0F, 8'hF0, 8'h7E, 1'b1);
      ale_style = MPBFE_ALE_HIGH;
      style_case(MPBFE_RD_STROBE, MPBFE_WR_STROBE, 1'b0, 3'h5, 3'h7);
      style_case(MPBFE_RD_ECLK, MPBFE_WR_RWLEVEL, 1'b0, 3'h7, 3'h5);
      style_case(MPBFE_RD_DSTROBE, MPBFE_WR_RWLEVEL, 1'b0, 3'h5, 3'h7);
      style_case(MPBFE_RD_FETCH, MPBFE_WR_STROBE, 1'b0, 3'h5, 3'h7);
      style_case(MPBFE_RD_STROBE, MPBFE_WR_STROBE, 1'b1, 3'h6, 3'h7);
      write_case(8'hA7);
      write_case(8'h58);
      fetch_case();
      do_reset();
      finish_test();
   end
endmodule : tb_top

// file: verilog/mpbfe_front_end.sv
// Host parallel bus front end: latches the host address, steers read data onto
// the address/data ports and forwards address and control levels to the logic array.
// Assumes the host pins are asynchronous; reads return data from the selected block.
// Function
// - Multiplexed host: low port carries address first, data later.
// - Separate buses: low port takes address bits zero to seven only.
// - Burst layout: low port A4..A11 with data, high port A12..A19.
// - Mux and non-mux hosts: high port is plain address eight to fifteen.
// - Page layout: high port carries multiplexed address and data eight to fifteen.
// - Address is captured on the latch enable or address strobe.
// - Ports driven only during active read with a block selected.
// - Received addresses are routed to decode and user logic.
// - Write control is active-low strobe or read/write level, by configuration.
// - Read control is read strobe, phase clock, data strobe or fetch enable.
// - Hosts with more than sixteen address bits read by fetch enable.
// - Write and read controls are fed into the logic array.
// - Fetch control is program fetch enable, or a generic logic input.
// - Reset initialises ports, logic outputs and the latched address.
// - Reset terminates any flash program or erase in progress.
`timescale 1ns/1ns
module mpbfe_front_end
   import mpbfe_pkg::*;
(
   input  wire logic                       ref_clk,
   input  wire logic                       arst_n,
   input  wire mpbfe_pkg::mpbfe_bus_e      bus_mode,
   input  wire mpbfe_pkg::mpbfe_wr_e       wr_style,
   input  wire mpbfe_pkg::mpbfe_rd_e       rd_style,
   input  wire mpbfe_pkg::mpbfe_ale_e      ale_style,
   input  wire logic                       wide_addr_host,
   input  wire logic                       fetch_is_enable,
   input  wire logic [mpbfe_pkg::ADW-1:0]  low_addr_data_port_i,
   output      logic [mpbfe_pkg::ADW-1:0]  low_addr_data_port_o,
   output      logic                       low_addr_data_port_oe,
   input  wire logic [mpbfe_pkg::ADW-1:0]  high_addr_data_port_i,
   output      logic [mpbfe_pkg::ADW-1:0]  high_addr_data_port_o,
   output      logic                       high_addr_data_port_oe,
   input  wire logic                       addr_strobe_in,
   input  wire logic                       write_ctrl_input,
   input  wire logic                       read_ctrl_input,
   input  wire logic                       fetch_ctrl_input,
   input  wire logic                       block_select,
   input  wire logic [mpbfe_pkg::ADW-1:0]  rd_data,
   output      logic [mpbfe_pkg::ADDR_W-1:0] latched_addr,
   output      logic [mpbfe_pkg::ADW-1:0]  wr_data,
   output      logic                       wr_pulse,
   output      logic                       rd_active,
   output      logic                       wr_ctrl_to_logic,
   output      logic                       rd_ctrl_to_logic,
   output      logic                       fetch_to_logic,
   output      logic                       generic_in_to_logic,
   output      logic                       flash_abort
);
   import mpbfe_pkg::*;

   localparam int CW = 4;
   logic [CW-1:0]  ctl_s;
   logic [ADW-1:0] lo_s;
   logic [ADW-1:0] hi_s;
   logic           ale_s;
   logic           wr_s;
   logic           rd_s;
   logic           fetch_s;
   logic           ale_prev_q;
   logic           wr_prev_q;
   logic           latch_ev;
   logic           rd_now;
   logic           wr_now;
   logic           hi_is_data;
   logic [ADW-1:0] lo_q_prev;

   // Controls reset to their idle levels, or the first edges after reset decode a false access
   mpbfe_sync #(.W(CW), .RST_VAL(CTL_IDLE)) u_ctl_sync (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .async_in ({addr_strobe_in, write_ctrl_input, read_ctrl_input, fetch_ctrl_input}),
      .sync_out (ctl_s)
   );
   mpbfe_sync #(.W(2*ADW)) u_ad_sync (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .async_in ({high_addr_data_port_i, low_addr_data_port_i}),
      .sync_out ({hi_s, lo_s})
   );
   assign ale_s   = ctl_s[3];
   assign wr_s    = ctl_s[2];
   assign rd_s    = ctl_s[1];
   assign fetch_s = ctl_s[0];

   // Address latch event: ALE latches while high (last value at fall), AS at its rise
   always_comb begin
      latch_ev = 1'b0;
      if (ale_style == MPBFE_AS_RISE)
         latch_ev = ale_s & ~ale_prev_q;
      else
         latch_ev = ale_s;
   end

   // Read qualifier per control style; a wide host always reads by fetch enable
   always_comb begin
      rd_now = 1'b0;
      if (wide_addr_host) begin
         rd_now = ~fetch_s;
      end else begin
         case (rd_style)
            MPBFE_RD_STROBE:  rd_now = ~rd_s;
            MPBFE_RD_ECLK:    rd_now = rd_s & (wr_style == MPBFE_WR_RWLEVEL) & wr_s;
            MPBFE_RD_DSTROBE: rd_now = ~rd_s & ((wr_style == MPBFE_WR_STROBE) | wr_s);
            MPBFE_RD_FETCH:   rd_now = ~rd_s;
            default:          rd_now = 1'b0;
         endcase
      end
      if (!wide_addr_host && fetch_is_enable && (rd_style == MPBFE_RD_STROBE))
         rd_now = rd_now | ~fetch_s;
   end

   // Write qualifier: strobe style is active low, level style pairs with the data strobe or the phase clock
   always_comb begin
      wr_now = 1'b0;
      if (wr_style == MPBFE_WR_STROBE)
         wr_now = ~wr_s;
      else if (rd_style == MPBFE_RD_ECLK)
         wr_now = ~wr_s & rd_s;
      else
         wr_now = ~wr_s & ~rd_s;
   end

   assign hi_is_data = (bus_mode == MPBFE_BUS_PAGE);

   // Address capture; held until the next latch event
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         latched_addr <= ADDR_RST;
      end else if (latch_ev) begin
         case (bus_mode)
            MPBFE_BUS_BURST:
               latched_addr <= {hi_s, lo_s, latched_addr[BURST_LO-1:0]};
            MPBFE_BUS_MUX, MPBFE_BUS_NONMUX, MPBFE_BUS_PAGE:
               latched_addr <= {latched_addr[ADDR_W-1:2*ADW], hi_s, lo_s};
            default:
               latched_addr <= latched_addr;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ale_prev_q <= 1'b0;
         wr_prev_q  <= 1'b0;
         lo_q_prev  <= BYTE_RST;
      end else begin
         ale_prev_q <= ale_s;
         wr_prev_q  <= wr_now;
         lo_q_prev  <= lo_s;
      end
   end

   // Write data sampled from the data lines; page layout carries data on the high port
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_data  <= BYTE_RST;
         wr_pulse <= 1'b0;
      end else begin
         wr_pulse <= wr_prev_q & ~wr_now;
         if (wr_now)
            wr_data <= hi_is_data ? hi_s : lo_q_prev;
      end
   end

   // Drive only during an active read of a selected block; non-mux data sits elsewhere
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_addr_data_port_o   <= BYTE_RST;
         low_addr_data_port_oe  <= 1'b0;
         high_addr_data_port_o  <= BYTE_RST;
         high_addr_data_port_oe <= 1'b0;
         rd_active              <= 1'b0;
      end else begin
         rd_active              <= rd_now & block_select;
         low_addr_data_port_oe  <= rd_now & block_select & ~latch_ev
                                   & (bus_mode != MPBFE_BUS_NONMUX) & ~hi_is_data;
         high_addr_data_port_oe <= rd_now & block_select & ~latch_ev & hi_is_data;
         low_addr_data_port_o   <= rd_data;
         high_addr_data_port_o  <= rd_data;
      end
   end

   // Control levels to the logic array; fetch input doubles as a generic input
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ctrl_to_logic    <= 1'b1;
         rd_ctrl_to_logic    <= 1'b1;
         fetch_to_logic      <= 1'b1;
         generic_in_to_logic <= 1'b0;
      end else begin
         wr_ctrl_to_logic    <= wr_s;
         rd_ctrl_to_logic    <= rd_s;
         fetch_to_logic      <= (fetch_is_enable | wide_addr_host) ? fetch_s : 1'b1;
         generic_in_to_logic <= (fetch_is_enable | wide_addr_host) ? 1'b0 : fetch_s;
      end
   end

   // Abort is held for the whole reset and clears at the first edge after it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         flash_abort <= 1'b1;
      else
         flash_abort <= 1'b0;
   end

   // Assertions
   property p_drive_needs_select;
      @(posedge ref_clk) disable iff (!arst_n)
      low_addr_data_port_oe |-> $past(block_select) && $past(rd_now);
   endproperty
   a_drive_needs_select: assert property (p_drive_needs_select) else $error("low port driven without read");

   property p_no_drive_nonmux;
      @(posedge ref_clk) disable iff (!arst_n)
      (bus_mode == MPBFE_BUS_NONMUX) && $stable(bus_mode) |-> !low_addr_data_port_oe;
   endproperty
   a_no_drive_nonmux: assert property (p_no_drive_nonmux) else $error("low port driven in non-mux mode");

   property p_hold_addr;
      @(posedge ref_clk) disable iff (!arst_n)
      !latch_ev |=> $stable(latched_addr);
   endproperty
   a_hold_addr: assert property (p_hold_addr) else $error("address changed without latch");

   property p_capture;
      @(posedge ref_clk) disable iff (!arst_n)
      latch_ev && (bus_mode == MPBFE_BUS_MUX) |=> latched_addr[ADW-1:0] == $past(lo_s);
   endproperty
   a_capture: assert property (p_capture) else $error("low address not captured");

   property p_burst;
      @(posedge ref_clk) disable iff (!arst_n)
      latch_ev && (bus_mode == MPBFE_BUS_BURST) |=> latched_addr[ADDR_W-1:BURST_HI] == $past(hi_s);
   endproperty
   a_burst: assert property (p_burst) else $error("burst high address wrong");

   property p_high_plain;
      @(posedge ref_clk) disable iff (!arst_n)
      (bus_mode == MPBFE_BUS_MUX) |=> !high_addr_data_port_oe;
   endproperty
   a_high_plain: assert property (p_high_plain) else $error("high port driven in mux mode");

   property p_wide_fetch;
      @(posedge ref_clk) disable iff (!arst_n)
      wide_addr_host && !fetch_s && block_select |=> rd_active;
   endproperty
   a_wide_fetch: assert property (p_wide_fetch) else $error("fetch read ignored");

   property p_ctrl_fwd;
      @(posedge ref_clk) disable iff (!arst_n)
      ##1 (wr_ctrl_to_logic == $past(wr_s)) && (rd_ctrl_to_logic == $past(rd_s));
   endproperty
   a_ctrl_fwd: assert property (p_ctrl_fwd) else $error("control not forwarded");

endmodule : mpbfe_front_end

// file: verilog/mpbfe_pkg.sv
// Package for the host parallel bus front end: bus modes, control styles, widths.
// Assumes a single 250 MHz clock domain and that all host pins are asynchronous to it.
package mpbfe_pkg;

   localparam int ADW = 8;                    // Width of each address/data port
   localparam int ADDR_W = 20;                // Internal latched address width
   localparam int PIPE_W = 2;                 // Synchroniser depth
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
   localparam logic [ADW-1:0] BYTE_RST = 8'h00;
   // Synchronised control reset: strobe idle low, active-low controls idle high,
   // so that leaving reset does not look like a read or a write
   localparam logic [3:0] CTL_IDLE = 4'h7;

   // Host bus wiring styles
   typedef enum logic [1:0] {
      MPBFE_BUS_MUX,        // Low port address then data, high port plain address
      MPBFE_BUS_NONMUX,     // Low port address bits 0..7 only, high port 8..15
      MPBFE_BUS_BURST,      // Low port A4/D0..A11/D7, high port A12..A19
      MPBFE_BUS_PAGE        // Low port address, high port multiplexed AD8..15
   } mpbfe_bus_e;

   // Meaning of the write control input
   typedef enum logic {
      MPBFE_WR_STROBE,      // Active-low write strobe
      MPBFE_WR_RWLEVEL      // High read, low write
   } mpbfe_wr_e;

   // Meaning of the read control input
   typedef enum logic [1:0] {
      MPBFE_RD_STROBE,      // Active-low read strobe
      MPBFE_RD_ECLK,        // Bus phase clock, high means data phase
      MPBFE_RD_DSTROBE,     // Active-low data strobe
      MPBFE_RD_FETCH        // Program fetch enable as active-low read
   } mpbfe_rd_e;

   // Address latch or strobe sense
   typedef enum logic {
      MPBFE_ALE_HIGH,       // Latch while high, hold at fall
      MPBFE_AS_RISE         // Latch at rising edge
   } mpbfe_ale_e;

   // Bit positions of the burst and page layouts
   localparam int BURST_LO = 4;
   localparam int BURST_HI = 12;
   localparam int PAGE_HI = 8;

endpackage : mpbfe_pkg

// file: verilog/mpbfe_sync.sv
// Two-flop synchroniser, one per bit, for host pins entering ref_clk.
// Assumes bits are independent levels; multi-bit words are only sampled once stable.
`timescale 1ns/1ns
module mpbfe_sync
   import mpbfe_pkg::*;
#(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] async_in,
   output      logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : mpbfe_sync
